// *** verilog/qdc_consts.svh ***
`ifndef QDC_CONSTS_SVH
`define QDC_CONSTS_SVH

// Frame geometry.
`define QDC_FRAME_BITS   24
`define QDC_NUM_CH       4
`define QDC_CODE_BITS    12
`define QDC_SYNC_STAGES  2

// Load-control field encodings.
`define QDC_LD_BUF       2'h0
`define QDC_LD_ONE       2'h1
`define QDC_LD_ALL       2'h2
`define QDC_LD_BCAST     2'h3

// Channel-select values: the one that addresses every channel when load control is 3, and channel A.
`define QDC_SEL_BCAST    2'h2
`define QDC_SEL_CH_A     2'h0

// Reference commands, carried in the top nibble of the code field.
`define QDC_REFCMD_DEFAULT 4'h0
`define QDC_REFCMD_ON      4'h1
`define QDC_REFCMD_OFF     4'h2

// Channel power-down modes, carried in the top two code bits.
`define QDC_PDM_UP       2'h0
`define QDC_PDM_1K       2'h1
`define QDC_PDM_100K     2'h2
`define QDC_PDM_HIZ      2'h3

// Reset values.
`define QDC_CODE_RESET   12'h000
`define QDC_PDM_RESET    2'h0

`endif

// *** verilog/qdc_pkg.sv ***
package qdc_pkg;

  typedef enum logic [2:0] {
    QDC_REF_DEFAULT   = 3'h1,
    QDC_REF_FORCED_ON = 3'h2,
    QDC_REF_FORCED_OFF = 3'h4
  } qdc_ref_t;

  // One 24-bit command frame, most significant field first.
  typedef struct packed {
    logic [1:0]  addr;
    logic [1:0]  load;
    logic        rsvd;
    logic [1:0]  sel;
    logic        pd;
    logic [11:0] code;
    logic [3:0]  pad;
  } qdc_frame_t;

  // State of one channel: power-down mode and code.
  typedef struct packed {
    logic [1:0]  pdm;
    logic [11:0] code;
  } qdc_chan_t;

endpackage : qdc_pkg

// *** verilog/qdc_link_rx.sv ***
`include "qdc_consts.svh"

module qdc_link_rx
  import qdc_pkg::*;
#(
  parameter int FRAME_BITS = `QDC_FRAME_BITS
) (
  input  wire logic                  sclk,
  input  wire logic                  rst,
  input  wire logic                  sync_n,
  input  wire logic                  sdin,
  output logic [FRAME_BITS-1:0]      word,
  output logic                       word_tgl,
  output logic                       edge_tgl
);

  localparam logic [4:0] LAST = 5'(FRAME_BITS - 1);
  localparam logic [4:0] FULL = 5'(FRAME_BITS);

  logic [FRAME_BITS-2:0] sh;
  logic [FRAME_BITS-2:0] next_sh;
  logic [4:0]            cnt;
  logic [4:0]            next_cnt;
  logic [FRAME_BITS-1:0] next_word;
  logic                  next_word_tgl;
  logic                  next_edge_tgl;
  logic                  frame_clr;

  // The serial clock stops between frames, so a raised frame select clears
  // the bit count by itself instead of waiting for an edge that never comes.
  assign frame_clr = rst | sync_n;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_sh       = {sh[FRAME_BITS-3:0], sdin};
    next_cnt      = cnt;
    next_word     = word;
    next_word_tgl = word_tgl;
    next_edge_tgl = ~edge_tgl;
    if (cnt < FULL) begin
      next_cnt = cnt + 5'h1;
    end
    if (cnt == LAST) begin
      next_word     = {sh, sdin};
      next_word_tgl = ~word_tgl;
    end
  end

  always_ff @(negedge sclk or posedge frame_clr) begin
    if (frame_clr) begin
      sh  <= '0;
      cnt <= 5'h0;
    end else begin
      sh  <= next_sh;
      cnt <= next_cnt;
    end
  end

  always_ff @(negedge sclk or posedge rst) begin
    if (rst) begin
      word     <= '0;
      word_tgl <= 1'b0;
      edge_tgl <= 1'b0;
    end else begin
      word     <= next_word;
      word_tgl <= next_word_tgl;
      edge_tgl <= next_edge_tgl;
    end
  end

endmodule : qdc_link_rx

// *** verilog/qdc_decoder.sv ***
`include "qdc_consts.svh"

module qdc_decoder
  import qdc_pkg::*;
#(
  parameter int NUM_CH = `QDC_NUM_CH
) (
  input  wire logic                 CLK_SYS,
  input  wire logic                 RST,
  input  wire logic                 SCLK,
  input  wire logic                 SYNC_N,
  input  wire logic                 SDIN,
  output qdc_chan_t [NUM_CH-1:0]    CH_OUT,
  output logic                      REF_ON,
  output qdc_ref_t                  REF_MODE,
  output logic                      LINK_ERROR,
  output logic                      FRAME_TAKEN
);

  logic [`QDC_FRAME_BITS-1:0] link_word;
  logic                       link_word_tgl;
  logic                       link_edge_tgl;

  // frames shift in MSB first on falling serial clock edges.
  qdc_link_rx #(
    .FRAME_BITS (`QDC_FRAME_BITS)
  ) u_link (
    .sclk     (SCLK),
    .rst      (RST),
    .sync_n   (SYNC_N),
    .sdin     (SDIN),
    .word     (link_word),
    .word_tgl (link_word_tgl),
    .edge_tgl (link_edge_tgl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Crossing into the system clock. The frame word is held stable in the
  // link domain until the next 24th edge, so only its toggle is synchronised.
  logic [2:0] word_sy;
  logic [2:0] edge_sy;
  logic [2:0] sel_sy;
  logic       frame_valid;
  logic       link_edge;
  logic       sel_rise;
  logic       sel_fall;

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      word_sy <= 3'h0;
      edge_sy <= 3'h0;
      sel_sy  <= 3'h7;
    end else begin
      word_sy <= {word_sy[1:0], link_word_tgl};
      edge_sy <= {edge_sy[1:0], link_edge_tgl};
      sel_sy  <= {sel_sy[1:0], SYNC_N};
    end
  end

  assign frame_valid = word_sy[2] ^ word_sy[1];
  assign link_edge   = edge_sy[2] ^ edge_sy[1];
  assign sel_rise    = sel_sy[1] & ~sel_sy[2];
  assign sel_fall    = ~sel_sy[1] & sel_sy[2];

  ////////////////////////////////////////////////////////////////////////////
  // Select-line watchdog.
  logic edge_seen;
  logic next_edge_seen;
  logic next_link_error;
  logic err_set;

  always_comb begin
    err_set         = sel_rise & ~edge_seen & ~link_edge;
    next_edge_seen  = edge_seen;
    next_link_error = LINK_ERROR;
    if (sel_fall) begin
      next_edge_seen = 1'b0;
    end
    if (link_edge) begin
      next_edge_seen = 1'b1;
    end
    if (frame_valid) begin
      next_link_error = 1'b0;
    end
    // A new violation outranks a clear arriving in the same cycle.
    if (err_set) begin
      next_link_error = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      edge_seen  <= 1'b0;
      LINK_ERROR <= 1'b0;
    end else begin
      edge_seen  <= next_edge_seen;
      LINK_ERROR <= next_link_error;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode.
  qdc_frame_t                f;
  qdc_chan_t  [NUM_CH-1:0]   buf_q;
  qdc_chan_t  [NUM_CH-1:0]   next_buf;
  qdc_chan_t  [NUM_CH-1:0]   next_out;
  qdc_chan_t                 entry;
  qdc_ref_t                  next_ref_mode;
  logic                      is_ref;
  logic                      is_bpd;
  logic                      is_bld;
  logic       [NUM_CH-1:0]   ch_up;
  logic                      next_ref_on;

  assign f      = qdc_frame_t'(link_word);
  assign is_ref = f.pd && f.sel == `QDC_SEL_CH_A && f.load == `QDC_LD_BUF
                  && f.code[11:10] == `QDC_PDM_UP;
  assign is_bpd = f.load == `QDC_LD_BCAST && f.sel == `QDC_SEL_BCAST && f.pd;
  assign is_bld = f.load == `QDC_LD_BCAST && f.sel == `QDC_SEL_BCAST && !f.pd;

  always_comb begin
    next_buf      = buf_q;
    next_out      = CH_OUT;
    next_ref_mode = REF_MODE;
    entry.pdm     = f.pd ? f.code[11:10] : `QDC_PDM_UP;
    entry.code    = f.pd ? buf_q[f.sel].code : f.code;
    if (frame_valid) begin
      if (is_ref) begin
        unique case (f.code[11:8])
          `QDC_REFCMD_DEFAULT: next_ref_mode = QDC_REF_DEFAULT;
          `QDC_REFCMD_ON:      next_ref_mode = QDC_REF_FORCED_ON;
          `QDC_REFCMD_OFF:     next_ref_mode = QDC_REF_FORCED_OFF;
          default:             next_ref_mode = REF_MODE;
        endcase
      end else if (is_bpd) begin
        for (int i = 0; i < NUM_CH; i++) begin
          next_buf[i].pdm = f.code[11:10];
        end
        next_out = next_buf;
      end else if (is_bld) begin
        for (int i = 0; i < NUM_CH; i++) begin
          next_buf[i] = '{pdm: `QDC_PDM_UP, code: f.code};
        end
        next_out = next_buf;
      end else begin
        next_buf[f.sel] = entry;
        unique case (f.load)
          `QDC_LD_ONE:   next_out[f.sel] = entry;
          `QDC_LD_ALL:   next_out = next_buf;
          `QDC_LD_BCAST: next_out = next_buf;
          default:       next_out = CH_OUT;
        endcase
      end
    end
  end

  for (genvar g = 0; g < NUM_CH; g++) begin : g_up
    assign ch_up[g] = next_out[g].pdm == `QDC_PDM_UP;
  end

  // The reference follows the channels only in default mode; a forced mode
  // ignores every channel write, which keeps a forced-off part off.
  always_comb begin
    unique case (REF_MODE)
      QDC_REF_FORCED_ON:  next_ref_on = 1'b1;
      QDC_REF_FORCED_OFF: next_ref_on = 1'b0;
      default:            next_ref_on = |ch_up;
    endcase
    if (next_ref_mode == QDC_REF_FORCED_OFF) begin
      next_ref_on = 1'b0;
    end else if (next_ref_mode == QDC_REF_FORCED_ON) begin
      next_ref_on = 1'b1;
    end else begin
      next_ref_on = |ch_up;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < NUM_CH; i++) begin
        buf_q[i]  <= '{pdm: `QDC_PDM_RESET, code: `QDC_CODE_RESET};
        CH_OUT[i] <= '{pdm: `QDC_PDM_RESET, code: `QDC_CODE_RESET};
      end
      REF_MODE    <= QDC_REF_DEFAULT;
      REF_ON      <= 1'b1;
      FRAME_TAKEN <= 1'b0;
    end else begin
      buf_q       <= next_buf;
      CH_OUT      <= next_out;
      REF_MODE    <= next_ref_mode;
      REF_ON      <= next_ref_on;
      FRAME_TAKEN <= frame_valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  a_ref_off_cmd: assert property (
    frame_valid && is_ref && f.code[11:8] == `QDC_REFCMD_OFF
      |=> REF_MODE == QDC_REF_FORCED_OFF && !REF_ON)
    else $error("reference off command not taken");

  a_ref_off_holds: assert property (
    REF_MODE == QDC_REF_FORCED_OFF && !(frame_valid && is_ref)
      |=> REF_MODE == QDC_REF_FORCED_OFF && !REF_ON)
    else $error("forced-off reference came back on");

  a_ref_default_cmd: assert property (
    frame_valid && is_ref && f.code[11:8] == `QDC_REFCMD_DEFAULT
      |=> REF_MODE == QDC_REF_DEFAULT)
    else $error("default reference command not taken");

  a_reset_ref_mode: assert property (
    $fell(RST) |-> REF_MODE == QDC_REF_DEFAULT && REF_ON)
    else $error("reference not in default mode after reset");

  a_bcast_load_all: assert property (
    frame_valid && is_bld
      |=> CH_OUT[0].code == $past(f.code) && CH_OUT[3].code == $past(f.code)
          && CH_OUT[1].pdm == `QDC_PDM_UP && CH_OUT[2].code == $past(f.code))
    else $error("broadcast load did not reach all channels");

  a_bcast_together: assert property (
    frame_valid && is_bld |-> ##1 FRAME_TAKEN && CH_OUT[1] == CH_OUT[2])
    else $error("broadcast outputs not updated together");

  a_bcast_hiz: assert property (
    frame_valid && is_bpd && f.code[11:10] == `QDC_PDM_HIZ
      |=> CH_OUT[0].pdm == `QDC_PDM_HIZ && CH_OUT[3].pdm == `QDC_PDM_HIZ)
    else $error("broadcast power-down not high impedance");

  a_auto_ref_down: assert property (
    REF_MODE == QDC_REF_DEFAULT && CH_OUT[0].pdm != `QDC_PDM_UP
      && CH_OUT[1].pdm != `QDC_PDM_UP && CH_OUT[2].pdm != `QDC_PDM_UP
      && CH_OUT[3].pdm != `QDC_PDM_UP |-> !REF_ON)
    else $error("reference on with every channel down");

  a_chan_a_load: assert property (
    frame_valid && f.load == `QDC_LD_ONE && f.sel == `QDC_SEL_CH_A && !f.pd
      |=> CH_OUT[0].code == $past(f.code) && CH_OUT[0].pdm == `QDC_PDM_UP)
    else $error("channel A load failed");

  a_auto_ref_up: assert property (
    REF_MODE == QDC_REF_DEFAULT && !REF_ON
      ##1 CH_OUT[0].pdm == `QDC_PDM_UP && $changed(CH_OUT[0].pdm) |-> REF_ON)
    else $error("reference not powered up with channel");

  a_others_hold: assert property (
    frame_valid && f.load == `QDC_LD_ONE && f.sel == `QDC_SEL_CH_A
      |=> $stable(CH_OUT[1]) && $stable(CH_OUT[2]) && $stable(CH_OUT[3]))
    else $error("single-channel load disturbed other channels");

  a_pd_mode_map: assert property (
    frame_valid && f.pd && f.load == `QDC_LD_ONE && f.sel == `QDC_SEL_BCAST
      |=> CH_OUT[2].pdm == $past(f.code[11:10]))
    else $error("power-down mode bits misplaced");

  a_load_all: assert property (
    frame_valid && f.load == `QDC_LD_ALL |=> CH_OUT == buf_q)
    else $error("load-all did not transfer every buffer");

  a_error_clear: assert property (
    frame_valid && !err_set |=> !LINK_ERROR)
    else $error("valid frame did not clear link error");

  c_bcast_load:  cover property (frame_valid && is_bld);
  c_ref_off:     cover property (REF_MODE == QDC_REF_FORCED_OFF ##[1:200] FRAME_TAKEN);
  c_auto_ref_up: cover property ($rose(REF_ON) && REF_MODE == QDC_REF_DEFAULT);
  c_link_error:  cover property ($rose(LINK_ERROR));

endmodule : qdc_decoder

// *** bench/qdc_host_model.sv ***
module qdc_host_model (
  output logic sclk,
  output logic sync_n,
  output logic sdin
);
  timeunit 1ns;
  timeprecision 1ps;

  time t24;

  ////////////////////////////////////////////////////////////////////////////////
  // The serial clock idles high and stands still between frames.
  initial begin
    sclk   = 1'b1;
    sync_n = 1'b1;
    sdin   = 1'b0;
    t24    = 0;
  end

  // Sends the first n bits of a frame, most significant first.
  task automatic send(input logic [23:0] f, input int n);
    #13;
    sync_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      sdin = f[23-i];
      #80 sclk = 1'b0;
      if (i == 23) begin
        t24 = $time;
      end
      #80 sclk = 1'b1;
    end
    #40 sync_n = 1'b1;
    // A released data line shows the inverse, so stale bits never look valid.
    sdin = ~sdin;
    #80;
  endtask : send

  // Pulses select with no serial clock edge in between.
  task automatic glitch();
    #13 sync_n = 1'b0;
    #100 sync_n = 1'b1;
    #200;
  endtask : glitch
endmodule : qdc_host_model

// *** bench/test_quad_dac_command_decoder.sv ***
`include "qdc_consts.svh"

module test_quad_dac_command_decoder
  import qdc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic              clk_sys;
  logic              rst;
  logic              sclk;
  logic              sync_n;
  logic              sdin;
  qdc_chan_t [3:0]   ch_out;
  qdc_chan_t [3:0]   exp_ch;
  logic              ref_on;
  qdc_ref_t          ref_mode;
  logic              link_error;
  logic              frame_taken;
  int                miscompares;
  int                checks_done;
  int                taken_cnt;
  time               lat;

  ////////////////////////////////////////////////////////////////////////////////
  qdc_host_model i_host (.sclk(sclk), .sync_n(sync_n), .sdin(sdin));

  qdc_decoder i_dut (
    .CLK_SYS     (clk_sys),
    .RST         (rst),
    .SCLK        (sclk),
    .SYNC_N      (sync_n),
    .SDIN        (sdin),
    .CH_OUT      (ch_out),
    .REF_ON      (ref_on),
    .REF_MODE    (ref_mode),
    .LINK_ERROR  (link_error),
    .FRAME_TAKEN (frame_taken)
  );

  initial begin
    clk_sys = 1'b0;
    rst     = 1'b1;
    forever #20 clk_sys = ~clk_sys;
  end

  // Latency is taken one edge after the pulse, so it spans three to four periods.
  always @(posedge clk_sys) begin
    if (frame_taken === 1'b1) begin
      taken_cnt <= taken_cnt + 1;
      lat       <= $time - i_host.t24;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic cmp_v(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_v

  task automatic cmp_ch(input qdc_chan_t [3:0] got, input qdc_chan_t [3:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_ch

  task automatic chk(input qdc_chan_t [3:0] e, input logic on, input qdc_ref_t m);
    cmp_ch(ch_out, e);
    cmp_v(ref_on, on);
    cmp_v(ref_mode, m);
  endtask : chk

  function automatic logic [23:0] mk(input logic [1:0] ld, input logic [1:0] sel,
                                     input logic pd, input logic [11:0] code);
    qdc_frame_t f;
    f = '{addr: 2'h0, load: ld, rsvd: 1'b0, sel: sel, pd: pd, code: code, pad: 4'ha};
    return f;
  endfunction : mk

  function automatic qdc_chan_t [3:0] all4(input logic [1:0] p, input logic [11:0] c);
    return {4{p, c}};
  endfunction : all4

  // Sends a whole frame and checks one pulse at the right distance from the last edge.
  task automatic frame(input logic [23:0] f);
    int n0;
    int k;
    n0 = taken_cnt;
    k  = 0;
    i_host.send(f, 24);
    while (taken_cnt == n0 && k < 12) begin
      @(posedge clk_sys);
      k++;
    end
    repeat (3) @(posedge clk_sys);
    #1;
    cmp_v(taken_cnt - n0, 1);
    cmp_v(lat > 120 && lat <= 200, 1);
  endtask : frame

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    @(posedge clk_sys);
    #1 rst = 1'b1;
    repeat (10) @(posedge clk_sys);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    chk(all4(`QDC_PDM_UP, `QDC_CODE_RESET), 1'b1, QDC_REF_DEFAULT);
    cmp_v(link_error, 0);
  endtask : t_reset

  task automatic t_bcast();
    frame(mk(`QDC_LD_BCAST, `QDC_SEL_BCAST, 1'b0, 12'ha5c));
    chk(all4(`QDC_PDM_UP, 12'ha5c), 1'b1, QDC_REF_DEFAULT);
    frame(mk(`QDC_LD_BCAST, `QDC_SEL_BCAST, 1'b1, 12'hc00));
    chk(all4(`QDC_PDM_HIZ, 12'ha5c), 1'b0, QDC_REF_DEFAULT);
  endtask : t_bcast

  task automatic t_chan();
    frame(mk(`QDC_LD_ONE, `QDC_SEL_CH_A, 1'b0, 12'h123));
    exp_ch    = all4(`QDC_PDM_HIZ, 12'ha5c);
    exp_ch[0] = '{pdm: `QDC_PDM_UP, code: 12'h123};
    chk(exp_ch, 1'b1, QDC_REF_DEFAULT);
    frame(mk(`QDC_LD_BUF, 2'h1, 1'b1, 12'h400));
    frame(mk(`QDC_LD_BUF, 2'h2, 1'b1, 12'h800));
    chk(exp_ch, 1'b1, QDC_REF_DEFAULT);
    frame(mk(`QDC_LD_ALL, 2'h3, 1'b0, 12'h777));
    exp_ch[1] = '{pdm: `QDC_PDM_1K, code: 12'ha5c};
    exp_ch[2] = '{pdm: `QDC_PDM_100K, code: 12'ha5c};
    exp_ch[3] = '{pdm: `QDC_PDM_UP, code: 12'h777};
    chk(exp_ch, 1'b1, QDC_REF_DEFAULT);
  endtask : t_chan

  task automatic t_ref();
    frame(mk(`QDC_LD_BUF, 2'h0, 1'b1, 12'h200));
    chk(exp_ch, 1'b0, QDC_REF_FORCED_OFF);
    frame(mk(`QDC_LD_BCAST, `QDC_SEL_BCAST, 1'b0, 12'h0ff));
    chk(all4(`QDC_PDM_UP, 12'h0ff), 1'b0, QDC_REF_FORCED_OFF);
    frame(mk(`QDC_LD_BUF, 2'h0, 1'b1, 12'h000));
    chk(all4(`QDC_PDM_UP, 12'h0ff), 1'b1, QDC_REF_DEFAULT);
  endtask : t_ref

  // A glitch latches the error; a truncated frame is dropped; a whole one clears it.
  task automatic t_link();
    int n0;
    i_host.glitch();
    repeat (6) @(posedge clk_sys);
    #1;
    cmp_v(link_error, 1);
    n0 = taken_cnt;
    i_host.send(mk(`QDC_LD_BCAST, `QDC_SEL_BCAST, 1'b0, 12'h555), 8);
    repeat (8) @(posedge clk_sys);
    #1;
    cmp_v(taken_cnt - n0, 0);
    cmp_ch(ch_out, all4(`QDC_PDM_UP, 12'h0ff));
    frame(mk(`QDC_LD_BUF, 2'h0, 1'b1, 12'h000));
    cmp_v(link_error, 0);
  endtask : t_link

  // Forced-on reference, a single-channel power-down and a load 3 with sel 0.
  task automatic t_force();
    frame(mk(`QDC_LD_BUF, 2'h0, 1'b1, 12'h100));
    chk(all4(`QDC_PDM_UP, 12'h0ff), 1'b1, QDC_REF_FORCED_ON);
    frame(mk(`QDC_LD_ONE, 2'h2, 1'b1, 12'hc00));
    exp_ch    = all4(`QDC_PDM_UP, 12'h0ff);
    exp_ch[2] = '{pdm: `QDC_PDM_HIZ, code: 12'h0ff};
    chk(exp_ch, 1'b1, QDC_REF_FORCED_ON);
    frame(mk(`QDC_LD_BCAST, `QDC_SEL_BCAST, 1'b1, 12'hc00));
    chk(all4(`QDC_PDM_HIZ, 12'h0ff), 1'b1, QDC_REF_FORCED_ON);
    frame(mk(`QDC_LD_BCAST, 2'h0, 1'b0, 12'h0ff));
    exp_ch    = all4(`QDC_PDM_HIZ, 12'h0ff);
    exp_ch[0] = '{pdm: `QDC_PDM_UP, code: 12'h0ff};
    chk(exp_ch, 1'b1, QDC_REF_FORCED_ON);
    frame(mk(`QDC_LD_BUF, 2'h0, 1'b1, 12'h000));
    chk(exp_ch, 1'b1, QDC_REF_DEFAULT);
  endtask : t_force

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    t_reset();
    t_bcast();
    t_chan();
    t_ref();
    t_link();
    t_force();
    frame(mk(`QDC_LD_BUF, 2'h0, 1'b1, 12'h200));
    cmp_v(ref_mode, QDC_REF_FORCED_OFF);
    t_reset();
    end_sim();
  end

  // Sixteen whole frames of about four microseconds each fit well inside this span.
  initial begin
    #1_000_000;
    miscompares++;
    end_sim();
  end
endmodule : test_quad_dac_command_decoder
